// >>> tcc_capcmp.sv
// Compare, capture, shared high-byte and interrupt flags for two timers
// Function
// - Each compare channel holds 16 bits, matches counter each tick, drives pin/irq.
// - Compare writes go through shared high-byte holder; both bytes update together.
// - Capture loads counter on pin edge, or comparator edge for first timer.
// - Capture slot may serve as counter top in selected waveform modes.
// - Capture reads use shared high-byte holder so both bytes match.
// - Vector requested only when enable, global flag and event flag all set.
// - Main mask: bit5 capture, bit4 compare A, bit3 compare B, bit2 wrap.
// - Extended mask: timer3 capture, A, B, wrap, C, and timer1 compare C.
// - Extended mask is absent while compatibility fuse is active.
// - Main flags reset to zero; bit5 capture, 4 A, 3 B, 2 wrap.
// - Capture flag on pin event, or on reaching top in top mode.
// - Flags clear on vector execution or writing one; zero leaves unchanged.
// - Compare flags set the cycle after counter equals compare value.
// - Force-compare strobe never sets a compare match flag.
// - Wrap flag follows the counter's overflow as its mode defines.
// - Timer3 compare B is 16-bit read/write, resetting to zero.
// - Extended flags hold timer3 and compare C flags, same set/clear.
`timescale 1ns/100ps
module tcc_capcmp (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tcc_pkg::tcc_timer_in_t t1_in,
  input wire tcc_pkg::tcc_timer_in_t t3_in,
  input wire logic t1_capture_input_pin,
  input wire logic t3_capture_input_pin,
  input wire logic analog_cmp_out,
  input wire logic compat_fuse,
  input wire logic global_irq_en,
  input wire logic [7:0] vec_ack_main,
  input wire logic [7:0] vec_ack_ext,
  output logic [7:0] irq_vec_main,
  output logic [7:0] irq_vec_ext,
  output logic irq,
  output logic [5:0] waveform_out_pin
);

  tcc_pkg::tcc_timer_in_t tin [2];
  logic [15:0] val_reg [tcc_pkg::NUM_VAL];
  logic [7:0] temp_reg;
  logic [7:0] mask_reg;
  logic [7:0] ext_mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] ext_flags_reg;
  logic [7:0] cap_ctrl_reg;
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [1:0] pin_last_reg;
  logic compat_meta_reg;
  logic compat_reg;
  logic [5:0] wave_reg;
  logic [5:0] cmp_hit;
  logic [1:0] cap_top;
  logic [1:0] top_hit;
  logic [1:0] cap_src;
  logic [1:0] cap_evt;
  logic [7:0] set_main;
  logic [7:0] set_ext;
  logic [7:0] eff_ext_mask;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_wr;
  logic do_rd;
  logic wr_en;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic wr_ok;
  logic [7:0] wbyte;
  tcc_pkg::tcc_dec_t wdec;
  tcc_pkg::tcc_dec_t rdec;
  logic [31:0] rd_word;
  logic rd_ok;

  // Address decode shared by the read and write paths
  function automatic tcc_pkg::tcc_dec_t dec(input logic [7:0] a);
    tcc_pkg::tcc_dec_t d;
    d = '0;
    if (a < tcc_pkg::OFS_MASK) begin
      d.val_hit = (a[1:0] == 2'h0);
      d.idx = a[5:3];
      d.low = a[2];
    end
    d.reg_hit = (a == tcc_pkg::OFS_MASK) || (a == tcc_pkg::OFS_EXT_MASK) ||
                (a == tcc_pkg::OFS_FLAGS) ||
                (a == tcc_pkg::OFS_EXT_FLAGS) ||
                (a == tcc_pkg::OFS_CAP_CTRL);
    return d;
  endfunction

  assign tin[0] = t1_in;
  assign tin[1] = t3_in;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      compat_meta_reg <= 1'b0;
      compat_reg <= 1'b0;
    end else if (clk_en) begin
      pin_meta_reg <= {analog_cmp_out, t3_capture_input_pin,
                       t1_capture_input_pin};
      pin_sync_reg <= pin_meta_reg;
      compat_meta_reg <= compat_fuse;
      compat_reg <= compat_meta_reg;
    end
  end

  // Edge detect history on the selected capture sources
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_last_reg <= 2'h0;
    end else if (clk_en) begin
      pin_last_reg <= cap_src;
    end
  end

  // Compare matches, top detection and capture events
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < tcc_pkg::CH_PER_TIMER; c++) begin
        cmp_hit[t * tcc_pkg::CH_PER_TIMER + c] = tin[t].tick &&
          (tin[t].count == val_reg[t * tcc_pkg::CH_PER_TIMER + c]);
      end
      cap_top[t] = tcc_pkg::CAP_TOP_MODES[tin[t].mode];
      top_hit[t] = cap_top[t] && tin[t].tick &&
        (tin[t].count == val_reg[tcc_pkg::IDX_CAP_BASE + t]);
    end
    // Switching the source while levels differ can fake one edge
    cap_src[0] = cap_ctrl_reg[tcc_pkg::CTL_T1_ACOMP] ?
                 pin_sync_reg[2] : pin_sync_reg[0];
    cap_src[1] = pin_sync_reg[1];
    for (int t = 0; t < 2; t++) begin
      // Pin is disconnected while the slot serves as top
      cap_evt[t] = !cap_top[t] && (cap_ctrl_reg[t] ?
        (cap_src[t] && !pin_last_reg[t]) :
        (!cap_src[t] && pin_last_reg[t]));
    end
  end

  // Flag set terms; force strobes are deliberately not among them
  always_comb begin
    set_main = 8'h00;
    set_ext = 8'h00;
    set_main[tcc_pkg::BIT_CAP] = cap_evt[0] || top_hit[0];
    set_main[tcc_pkg::BIT_CMP_A] = cmp_hit[0];
    set_main[tcc_pkg::BIT_CMP_B] = cmp_hit[1];
    set_main[tcc_pkg::BIT_WRAP] = tin[0].wrap;
    set_ext[tcc_pkg::BIT_CAP] = cap_evt[1] || top_hit[1];
    set_ext[tcc_pkg::BIT_CMP_A] = cmp_hit[3];
    set_ext[tcc_pkg::BIT_CMP_B] = cmp_hit[4];
    set_ext[tcc_pkg::BIT_WRAP] = tin[1].wrap;
    set_ext[tcc_pkg::BIT_T3_CMP_C] = cmp_hit[5];
    set_ext[tcc_pkg::BIT_T1_CMP_C] = cmp_hit[2];
  end

  // Bus handshakes and write decode
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  assign do_rd = s_axi_arvalid && !rvalid_reg;
  assign wdec = dec(aw_addr_reg);
  assign rdec = dec(s_axi_araddr);
  assign wbyte = w_data_reg[7:0];
  // Extended mask vanishes from the map under compatibility
  assign wr_ok = wdec.val_hit || (wdec.reg_hit && !(compat_reg &&
                 aw_addr_reg == tcc_pkg::OFS_EXT_MASK));
  assign wr_en = do_wr && wr_ok && w_strb_reg[0];
  assign wr_low = wr_en && wdec.val_hit && wdec.low;
  assign wr_high = wr_en && wdec.val_hit && !wdec.low;
  assign rd_low = do_rd && rdec.val_hit && rdec.low;

  // Write address and data are taken in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= tcc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data mux; high words return the shared holder
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (rdec.val_hit) begin
      rd_word[7:0] = rdec.low ? val_reg[rdec.idx][7:0] : temp_reg;
    end else begin
      unique case (s_axi_araddr)
        tcc_pkg::OFS_MASK: rd_word[7:0] = mask_reg;
        tcc_pkg::OFS_EXT_MASK: begin
          rd_word[7:0] = eff_ext_mask;
          rd_ok = !compat_reg;
        end
        tcc_pkg::OFS_FLAGS: rd_word[7:0] = flags_reg;
        tcc_pkg::OFS_EXT_FLAGS: rd_word[7:0] = ext_flags_reg;
        tcc_pkg::OFS_CAP_CTRL: rd_word[7:0] = cap_ctrl_reg;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= tcc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (do_rd) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Shared high-byte holder; a low read outranks a high write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_reg <= tcc_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (rd_low) begin
        temp_reg <= val_reg[rdec.idx][15:8];
      end else if (wr_high) begin
        temp_reg <= wbyte;
      end
    end
  end

  // Value slots; a capture outranks a CPU write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tcc_pkg::NUM_VAL; i++) begin
        val_reg[i] <= tcc_pkg::RST_VAL16;
      end
    end else if (clk_en) begin
      if (wr_low) begin
        val_reg[wdec.idx] <= {temp_reg, wbyte};
      end
      for (int t = 0; t < 2; t++) begin
        if (cap_evt[t]) begin
          val_reg[tcc_pkg::IDX_CAP_BASE + t] <= tin[t].count;
        end
      end
    end
  end

  // Masks and capture control; reserved bits are never stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= tcc_pkg::RST_BYTE;
      ext_mask_reg <= tcc_pkg::RST_BYTE;
      cap_ctrl_reg <= tcc_pkg::RST_BYTE;
    end else if (clk_en && wr_en && !wdec.val_hit) begin
      unique case (aw_addr_reg)
        tcc_pkg::OFS_MASK: mask_reg <= wbyte & tcc_pkg::MAIN_USED;
        tcc_pkg::OFS_EXT_MASK:
          ext_mask_reg <= wbyte & tcc_pkg::EXT_USED;
        tcc_pkg::OFS_CAP_CTRL:
          cap_ctrl_reg <= wbyte & tcc_pkg::CAP_CTRL_USED;
        default: ;
      endcase
    end
  end

  // Sticky flags: set wins over a write-one or vector clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= tcc_pkg::RST_BYTE;
      ext_flags_reg <= tcc_pkg::RST_BYTE;
    end else if (clk_en) begin
      flags_reg <= tcc_pkg::MAIN_USED & (set_main | (flags_reg &
        ~(vec_ack_main | ((wr_en && aw_addr_reg == tcc_pkg::OFS_FLAGS) ?
        wbyte : 8'h00))));
      ext_flags_reg <= tcc_pkg::EXT_USED & (set_ext | (ext_flags_reg &
        ~(vec_ack_ext | ((wr_en && aw_addr_reg == tcc_pkg::OFS_EXT_FLAGS) ?
        wbyte : 8'h00))));
    end
  end

  // Match toggles the channel pin; force toggles it without a flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_reg <= 6'h00;
    end else if (clk_en) begin
      wave_reg <= wave_reg ^ cmp_hit ^
                  {t3_in.force_cmp, t1_in.force_cmp};
    end
  end

  // Vector requests need enable, global flag and event flag
  assign eff_ext_mask = compat_reg ? 8'h00 : ext_mask_reg;
  assign irq_vec_main = flags_reg & mask_reg & {8{global_irq_en}};
  assign irq_vec_ext = ext_flags_reg & eff_ext_mask & {8{global_irq_en}};
  assign irq = |{irq_vec_main, irq_vec_ext};
  assign waveform_out_pin = wave_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  cmp_a_flag_a: assert property (clk_en && cmp_hit[0] |=>
    flags_reg[tcc_pkg::BIT_CMP_A]) else $error("compare A flag missed");
  force_no_flag_a: assert property (
    $rose(flags_reg[tcc_pkg::BIT_CMP_B]) |-> $past(cmp_hit[1]))
    else $error("compare B flag set without match");
  cap_load_a: assert property (clk_en && cap_evt[0] |=>
    val_reg[6] == $past(t1_in.count)) else $error("capture not loaded");
  cap_top_a: assert property (clk_en && cap_top[0] &&
    !(wr_low && wdec.idx == 3'h6) |=> $stable(val_reg[6]))
    else $error("capture taken in top mode");
  top_flag_a: assert property (clk_en && top_hit[0] |=>
    flags_reg[tcc_pkg::BIT_CAP]) else $error("top flag missed");
  irq_gate_a: assert property (irq |-> global_irq_en &&
    ((flags_reg & mask_reg) != 8'h00 || (ext_flags_reg & eff_ext_mask)
    != 8'h00)) else $error("interrupt without cause");
  commit_a: assert property (clk_en && wr_low && !cap_evt[0] &&
    !cap_evt[1] |=> val_reg[$past(wdec.idx)] ==
    {$past(temp_reg), $past(wbyte)}) else $error("16-bit commit wrong");
  rd_latch_a: assert property (clk_en && rd_low |=>
    temp_reg == $past(val_reg[rdec.idx][15:8]))
    else $error("high byte not latched");
  w1c_clear_a: assert property (clk_en && wr_en &&
    aw_addr_reg == tcc_pkg::OFS_FLAGS && wbyte[2] && !set_main[2]
    |=> !flags_reg[2]) else $error("write one did not clear");
  wrap_flag_a: assert property (clk_en && t3_in.wrap |=>
    ext_flags_reg[tcc_pkg::BIT_WRAP]) else $error("wrap flag missed");
  ext_c_flag_a: assert property (clk_en && cmp_hit[2] |=>
    ext_flags_reg[tcc_pkg::BIT_T1_CMP_C]) else $error("C flag missed");
  compat_mask_a: assert property (compat_reg |->
    irq_vec_ext == 8'h00) else $error("extended irq in compat mode");
  mask_bits_a: assert property (
    (mask_reg & ~tcc_pkg::MAIN_USED) == 8'h00 && ext_mask_reg[7:6] == 2'h0)
    else $error("reserved mask bit");

endmodule // tcc_capcmp

// >>> tcc_irq_model.sv
// Interrupt controller model that runs pending timer vectors
`timescale 1ns/100ps
module tcc_irq_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ack_on,
  input wire logic [7:0] irq_vec_main,
  input wire logic [7:0] irq_vec_ext,
  output logic [7:0] vec_ack_main,
  output logic [7:0] vec_ack_ext
);
  logic [1:0] hold_reg;
  // One vector at a time, lowest first; the pause lets the flag drop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_ack_main <= 8'h00;
      vec_ack_ext <= 8'h00;
      hold_reg <= 2'h0;
    end else if (hold_reg != 2'h0) begin
      vec_ack_main <= 8'h00;
      vec_ack_ext <= 8'h00;
      hold_reg <= hold_reg - 2'h1;
    end else if (ack_on && irq_vec_main != 8'h00) begin
      vec_ack_main <= irq_vec_main & (~irq_vec_main + 8'h01);
      hold_reg <= 2'h3;
    end else if (ack_on && irq_vec_ext != 8'h00) begin
      vec_ack_ext <= irq_vec_ext & (~irq_vec_ext + 8'h01);
      hold_reg <= 2'h3;
    end
  end
endmodule // tcc_irq_model

// >>> tcc_pkg.sv
// Constants and carrier types for the timer compare/capture block
package tcc_pkg;
  // Register map, byte addresses on the register bus
  localparam logic [7:0] OFS_VAL_BASE = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h40;
  localparam logic [7:0] OFS_EXT_MASK = 8'h44;
  localparam logic [7:0] OFS_FLAGS = 8'h48;
  localparam logic [7:0] OFS_EXT_FLAGS = 8'h4c;
  localparam logic [7:0] OFS_CAP_CTRL = 8'h50;
  // Sixteen-bit value slots; each has a high word then a low word
  localparam int NUM_VAL = 8;
  localparam int CH_PER_TIMER = 3;
  localparam int IDX_CAP_BASE = 6;
  // Flag and enable bit positions
  localparam int BIT_CAP = 5;
  localparam int BIT_CMP_A = 4;
  localparam int BIT_CMP_B = 3;
  localparam int BIT_WRAP = 2;
  localparam int BIT_T3_CMP_C = 1;
  localparam int BIT_T1_CMP_C = 0;
  localparam logic [7:0] MAIN_USED = 8'h3c;
  localparam logic [7:0] EXT_USED = 8'h3f;
  // Capture control bits
  localparam int CTL_T1_EDGE = 0;
  localparam int CTL_T3_EDGE = 1;
  localparam int CTL_T1_ACOMP = 2;
  localparam logic [7:0] CAP_CTRL_USED = 8'h07;
  // Waveform modes in which the capture slot is the counter top
  localparam logic [15:0] CAP_TOP_MODES = 16'h5500;
  // Reset values
  localparam logic [15:0] RST_VAL16 = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-timer signals from the counter logic
  typedef struct packed {
    logic [15:0] count;
    logic tick;
    logic wrap;
    logic [3:0] mode;
    logic [2:0] force_cmp;
  } tcc_timer_in_t;

  // Decoded register address
  typedef struct packed {
    logic val_hit;
    logic [2:0] idx;
    logic low;
    logic reg_hit;
  } tcc_dec_t;
endpackage

// >>> timer16_compare_capture_irq_tb.sv
// Self-checking bench for the timer compare/capture block
`timescale 1ns/100ps
module timer16_compare_capture_irq_tb;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, ack_on = 1'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  tcc_pkg::tcc_timer_in_t t1_in = '0, t3_in = '0;
  logic t1_capture_input_pin = 1'h0, t3_capture_input_pin = 1'h0;
  logic analog_cmp_out = 1'h0, compat_fuse = 1'h0, global_irq_en = 1'h0;
  logic [7:0] vec_ack_main, vec_ack_ext, irq_vec_main, irq_vec_ext;
  logic [5:0] waveform_out_pin, wave_exp = 6'h00;
  logic [15:0] v, vals [6];
  integer err_total = 0, checked = 0, cyc = 0, seed = 32'h83f5c131;

  tcc_capcmp u_tcc_capcmp (.sys_clk, .rst_n, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .t1_in,
    .t3_in, .t1_capture_input_pin, .t3_capture_input_pin, .analog_cmp_out,
    .compat_fuse, .global_irq_en, .vec_ack_main, .vec_ack_ext,
    .irq_vec_main, .irq_vec_ext, .irq, .waveform_out_pin);

  tcc_irq_model u_tcc_irq_model (.sys_clk, .rst_n, .ack_on, .irq_vec_main,
    .irq_vec_ext, .vec_ack_main, .vec_ack_ext);

  // Clock and hang guard; the run needs far fewer cycles than this
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test;
    end
  end

  task automatic stop_test;
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Bus tasks start and end just after a rising edge; ready is seen at
  // the falling edge so the hold lasts up to the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                    output logic [1:0] rs);
    logic aw_hit, w_hit, b_hit;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b_hit = 1'h0;
    while (!b_hit) begin
      @(negedge sys_clk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_hit) s_axi_awvalid <= 1'h0;
      if (w_hit) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dt,
                    output logic [1:0] rs);
    logic ar_hit, r_hit;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r_hit = 1'h0;
    while (!r_hit) begin
      @(negedge sys_clk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rvalid;
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_hit) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask

  // Sixteen-bit access: high then low to write, low then high to read
  task automatic wr16(input int i, input logic [15:0] val);
    wr(8'(8 * i), {24'h0, val[15:8]}, r);
    wr(8'(8 * i + 4), {24'h0, val[7:0]}, r);
  endtask

  task automatic rd16(input int i, output logic [15:0] val);
    logic [31:0] lo, hi;
    rd(8'(8 * i + 4), lo, r);
    rd(8'(8 * i), hi, r);
    val = {hi[7:0], lo[7:0]};
  endtask

  // One timer tick with the given count on the chosen timer
  task automatic tick(input logic t3, input logic [15:0] c);
    t1_in.count <= c;
    t3_in.count <= c;
    t1_in.tick <= !t3;
    t3_in.tick <= t3;
    @(posedge sys_clk);
    t1_in.tick <= 1'h0;
    t3_in.tick <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 8 && irq !== lvl; n++) @(negedge sys_clk);
    chk(irq, lvl);
    @(posedge sys_clk);
  endtask

  // Main flags expected from a timer 1 tick at count c
  function automatic logic [31:0] hit_bits(input logic [15:0] c);
    hit_bits = 32'h0;
    if (c == vals[0]) hit_bits[tcc_pkg::BIT_CMP_A] = 1'h1;
    if (c == vals[1]) hit_bits[tcc_pkg::BIT_CMP_B] = 1'h1;
  endfunction

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(tcc_pkg::OFS_FLAGS, d, r);
    chk(d, 32'h0);
    rd16(4, v);
    chk(v, 16'h0);
    for (int i = 0; i < 6; i++) begin
      vals[i] = 16'($random(seed));
      wr16(i, vals[i]);
      rd16(i, v);
      chk(v, vals[i]);
    end
    wr(tcc_pkg::OFS_MASK, 32'hff, r);
    rd(tcc_pkg::OFS_MASK, d, r);
    chk(d, 32'(tcc_pkg::MAIN_USED));
    wr(tcc_pkg::OFS_EXT_MASK, 32'h3f, r);
    rd(tcc_pkg::OFS_EXT_MASK, d, r);
    chk(d, 32'(tcc_pkg::EXT_USED));
    rd(8'h60, d, r);
    chk(r, tcc_pkg::RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      tick(1'h0, vals[k]);
      d = hit_bits(vals[k]);
      wave_exp = wave_exp ^ {4'h0, d[3], d[4]};
      rd(tcc_pkg::OFS_FLAGS, d, r);
      chk(d, hit_bits(vals[k]));
      chk(waveform_out_pin, wave_exp);
      wr(tcc_pkg::OFS_FLAGS, d, r);
      rd(tcc_pkg::OFS_FLAGS, d, r);
      chk(d, 32'h0);
    end
    t1_in.force_cmp <= 3'h1;
    t1_in.wrap <= 1'h1;
    @(posedge sys_clk);
    t1_in.force_cmp <= 3'h0;
    t1_in.wrap <= 1'h0;
    @(posedge sys_clk);
    rd(tcc_pkg::OFS_FLAGS, d, r);
    chk(d, 32'h4);
    wave_exp = wave_exp ^ 6'h01;
    chk(waveform_out_pin, wave_exp);
    wait_irq(1'h0);
    global_irq_en <= 1'h1;
    wait_irq(1'h1);
    chk(irq_vec_main, 8'h4);
    ack_on <= 1'h1;
    wait_irq(1'h0);
    ack_on <= 1'h0;
    tick(1'h1, vals[4]);
    wave_exp = wave_exp ^ 6'h10;
    rd(tcc_pkg::OFS_EXT_FLAGS, d, r);
    chk(d, 32'h8);
    chk(irq_vec_ext, 8'h8);
    chk(waveform_out_pin, wave_exp);
    ack_on <= 1'h1;
    wait_irq(1'h0);
    rd(tcc_pkg::OFS_EXT_FLAGS, d, r);
    chk(d, 32'h0);
    ack_on <= 1'h0;
    global_irq_en <= 1'h0;
    wr(tcc_pkg::OFS_CAP_CTRL, 32'h1, r);
    v = 16'($random(seed));
    t1_in.count <= v;
    t1_capture_input_pin <= 1'h1;
    repeat (5) @(posedge sys_clk);
    rd16(6, d[15:0]);
    chk(d[15:0], v);
    rd(tcc_pkg::OFS_FLAGS, d, r);
    chk(d, 32'h20);
    wr(tcc_pkg::OFS_FLAGS, 32'h20, r);
    wr(tcc_pkg::OFS_CAP_CTRL, 32'h5, r);
    v = 16'($random(seed));
    t1_in.count <= v;
    analog_cmp_out <= 1'h1;
    repeat (5) @(posedge sys_clk);
    rd16(6, d[15:0]);
    chk(d[15:0], v);
    wr(tcc_pkg::OFS_FLAGS, 32'h20, r);
    t1_in.mode <= 4'h8;
    wr16(6, 16'h1234);
    tick(1'h0, 16'h1234);
    rd(tcc_pkg::OFS_FLAGS, d, r);
    chk(d & 32'h20, 32'h20);
    compat_fuse <= 1'h1;
    repeat (4) @(posedge sys_clk);
    wr(tcc_pkg::OFS_EXT_MASK, 32'h3f, r);
    chk(r, tcc_pkg::RESP_SLVERR);
    rd(tcc_pkg::OFS_EXT_MASK, d, r);
    chk(d, 32'h0);
    chk(r, tcc_pkg::RESP_SLVERR);
    // A match while frozen must leave flags and pins alone
    clk_en <= 1'h0;
    tick(1'h0, vals[0]);
    clk_en <= 1'h1;
    rd(tcc_pkg::OFS_FLAGS, d, r);
    chk(d & 32'h10, 32'h0);
    chk(waveform_out_pin, wave_exp);
    stop_test;
  end
endmodule // timer16_compare_capture_irq_tb
